// *** logic/iovfh_pkg.sv ***
// constants, enums and carriers for the input over-voltage fault handler
package iovfh_pkg;
    // management bus command codes
    localparam logic [7:0] CMD_OV_FAULT_LIM = 8'h55;
    localparam logic [7:0] CMD_OV_RESP = 8'h56;
    localparam logic [7:0] CMD_OV_WARN_LIM = 8'h57;
    localparam logic [7:0] CMD_UV_WARN_LIM = 8'h58;
    localparam logic [7:0] CMD_IN_STATUS = 8'hF1;
    // fault-action byte fields
    localparam int RESP_MSB = 7;
    localparam int RESP_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DLY_MSB = 2;
    localparam int DLY_LSB = 0;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [1:0] RESP_DELAYED = 2'h1;
    localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
    localparam logic [1:0] RESP_LATCH = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // status bit positions
    localparam int STB_OV_FAULT = 0;
    localparam int STB_OV_WARN = 1;
    localparam int STB_UV_WARN = 2;
    localparam int STB_LATCHED = 3;
    // reset values
    localparam logic [15:0] RST_OV_FAULT_LIM = 16'hFFFF;
    localparam logic [7:0] RST_OV_RESP = 8'h80;
    localparam logic [15:0] RST_OV_WARN_LIM = 16'hFFFF;
    localparam logic [15:0] RST_UV_WARN_LIM = 16'h0000;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_RUN = 3'b001,
        ST_DELAY = 3'b010,
        ST_RETRY = 3'b011,
        ST_LATCH = 3'b100
    } iovfh_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] code;
        logic [15:0] wdata;
    } iovfh_req_s;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] rdata;
    } iovfh_rsp_s;
endpackage

// *** logic/iovfh_level_cmp.sv ***
// registered threshold comparator, above or below a limit
`timescale 1ns/1ps
module iovfh_level_cmp #(
    parameter int W = 16,
    parameter bit ABOVE = 1'b1
) (
    // clock and control
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    // compare
    input wire logic [W-1:0] level,
    input wire logic [W-1:0] limit,
    output logic hit
);
    logic hit_ff;

    // codes compared as unsigned, both sides share one exponent
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            hit_ff <= 1'b0;
        end else if (ce) begin
            hit_ff <= ABOVE ? (level > limit) : (level < limit);
        end
    end

    assign hit = hit_ff;
endmodule

// *** logic/iovfh_delay_timer.sv ***
// delay of 2**code time units, each unit_ticks clock cycles long
`timescale 1ns/1ps
module iovfh_delay_timer #(
    parameter int TICK_W = 16
) (
    // clock and control
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    // control
    input wire logic start,
    input wire logic stop,
    input wire logic [2:0] code,
    input wire logic [TICK_W-1:0] unit_ticks,
    // status
    output logic busy,
    output logic done
);
    logic busy_ff;
    logic done_ff;
    logic [TICK_W-1:0] tick_ff;
    logic [7:0] units_ff;
    logic [TICK_W-1:0] ticks_eff;

    // a zero unit length would take 2**TICK_W cycles per unit, so it counts as one cycle
    assign ticks_eff = (unit_ticks == '0) ? TICK_W'(1) : unit_ticks;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            tick_ff <= '0;
            units_ff <= 8'h00;
        end else if (ce) begin
            done_ff <= 1'b0;
            if (start) begin
                busy_ff <= 1'b1;
                tick_ff <= ticks_eff;
                units_ff <= 8'h01 << code;
            end else if (stop) begin
                busy_ff <= 1'b0;
            end else if (busy_ff) begin
                if (tick_ff == TICK_W'(1)) begin
                    if (units_ff == 8'h01) begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                    end else begin
                        units_ff <= units_ff - 8'h01;
                        tick_ff <= ticks_eff;
                    end
                end else begin
                    tick_ff <= tick_ff - TICK_W'(1);
                end
            end
        end
    end

    assign busy = busy_ff;
    assign done = done_ff;

    AST_TMR_UNITS: assert property (@(posedge mclk) disable iff (!resetn)
        ce && start |=> units_ff == (8'h01 << $past(code)))
        else $error("delay unit count does not match code");
endmodule

// *** logic/iovfh_top.sv ***
// input over-voltage supervision: limits, fault action and retry sequencer
`timescale 1ns/1ps
module iovfh_top #(
    parameter int TICK_W = 16
) (
    // clock and control
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    // management command port
    input wire iovfh_pkg::iovfh_req_s req,
    output iovfh_pkg::iovfh_rsp_s rsp,
    // measurement and system controls
    input wire logic [15:0] vin_meas,
    input wire logic [TICK_W-1:0] delay_unit_ticks,
    input wire logic maker_extra_option_settings,
    input wire logic on_command,
    input wire logic clear_faults,
    input wire logic other_fault_off,
    // results
    output logic output_enable,
    output logic ratio_regulation_mode,
    output logic [3:0] input_status
);
    logic [15:0] ov_fault_lim_ff;
    logic [7:0] ov_resp_ff;
    logic [15:0] ov_warn_lim_ff;
    logic [15:0] uv_warn_lim_ff;
    logic [3:0] status_ff;
    iovfh_pkg::iovfh_rsp_s rsp_ff;
    iovfh_pkg::iovfh_state_e state_ff;
    iovfh_pkg::iovfh_state_e nxt_state;
    logic [2:0] attempts_ff;
    logic [2:0] nxt_attempts;
    logic out_en_ff;
    logic ratio_ff;
    logic ov_hit;
    logic ovw_hit;
    logic uvw_hit;
    logic tmr_start;
    logic tmr_stop;
    logic tmr_done;
    logic status_wr;
    logic host_clr_fault;
    logic [1:0] resp_code;
    logic [2:0] retry_code;
    logic [2:0] dly_code;

    assign resp_code = ov_resp_ff[iovfh_pkg::RESP_MSB:iovfh_pkg::RESP_LSB];
    assign retry_code = ov_resp_ff[iovfh_pkg::RETRY_MSB:iovfh_pkg::RETRY_LSB];
    assign dly_code = ov_resp_ff[iovfh_pkg::DLY_MSB:iovfh_pkg::DLY_LSB];
    assign status_wr = req.wr && (req.code == iovfh_pkg::CMD_IN_STATUS);
    assign host_clr_fault = status_wr && req.wdata[iovfh_pkg::STB_OV_FAULT];

    // limit comparators
    iovfh_level_cmp #(.W(16), .ABOVE(1'b1)) u_ov_fault (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .level(vin_meas),
        .limit(ov_fault_lim_ff),
        .hit(ov_hit)
    );
    iovfh_level_cmp #(.W(16), .ABOVE(1'b1)) u_ov_warn (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .level(vin_meas),
        .limit(ov_warn_lim_ff),
        .hit(ovw_hit)
    );
    iovfh_level_cmp #(.W(16), .ABOVE(1'b0)) u_uv_warn (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .level(vin_meas),
        .limit(uv_warn_lim_ff),
        .hit(uvw_hit)
    );

    iovfh_delay_timer #(.TICK_W(TICK_W)) u_timer (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .start(tmr_start),
        .stop(tmr_stop),
        .code(dly_code),
        .unit_ticks(delay_unit_ticks),
        .busy(),
        .done(tmr_done)
    );

    // configuration writes
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ov_fault_lim_ff <= iovfh_pkg::RST_OV_FAULT_LIM;
            ov_resp_ff <= iovfh_pkg::RST_OV_RESP;
            ov_warn_lim_ff <= iovfh_pkg::RST_OV_WARN_LIM;
            uv_warn_lim_ff <= iovfh_pkg::RST_UV_WARN_LIM;
        end else if (ce && req.wr) begin
            case (req.code)
                iovfh_pkg::CMD_OV_FAULT_LIM: ov_fault_lim_ff <= req.wdata;
                iovfh_pkg::CMD_OV_RESP: ov_resp_ff <= req.wdata[7:0];
                iovfh_pkg::CMD_OV_WARN_LIM: ov_warn_lim_ff <= req.wdata;
                iovfh_pkg::CMD_UV_WARN_LIM: uv_warn_lim_ff <= req.wdata;
                default: ;
            endcase
        end
    end

    // read answers, one cycle after the request
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rsp_ff <= '0;
        end else if (ce) begin
            rsp_ff.valid <= req.rd || req.wr;
            rsp_ff.err <= 1'b0;
            rsp_ff.rdata <= 16'h0000;
            case (req.code)
                iovfh_pkg::CMD_OV_FAULT_LIM: rsp_ff.rdata <= ov_fault_lim_ff;
                iovfh_pkg::CMD_OV_RESP: rsp_ff.rdata <= {8'h00, ov_resp_ff};
                iovfh_pkg::CMD_OV_WARN_LIM: rsp_ff.rdata <= ov_warn_lim_ff;
                iovfh_pkg::CMD_UV_WARN_LIM: rsp_ff.rdata <= uv_warn_lim_ff;
                iovfh_pkg::CMD_IN_STATUS: rsp_ff.rdata <= {12'h000, status_ff};
                default: rsp_ff.err <= req.rd || req.wr;
            endcase
            if (!req.rd) begin
                rsp_ff.rdata <= 16'h0000;
            end
        end
    end

    // sticky flags 0 to 2, bit 3 follows the latch state: a new detection beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status_ff <= 4'h0;
        end else if (ce) begin
            for (int i = 0; i < 3; i++) begin
                if (clear_faults || (status_wr && req.wdata[i])) begin
                    status_ff[i] <= 1'b0;
                end
            end
            if (ov_hit) begin
                status_ff[iovfh_pkg::STB_OV_FAULT] <= 1'b1;
            end
            if (ovw_hit) begin
                status_ff[iovfh_pkg::STB_OV_WARN] <= 1'b1;
            end
            if (uvw_hit) begin
                status_ff[iovfh_pkg::STB_UV_WARN] <= 1'b1;
            end
            status_ff[iovfh_pkg::STB_LATCHED] <= (nxt_state == iovfh_pkg::ST_LATCH);
        end
    end

    // fault sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_attempts = attempts_ff;
        tmr_start = 1'b0;
        if (!on_command || other_fault_off) begin
            // commanded off ends any retry run, also the endless one
            nxt_state = iovfh_pkg::ST_OFF;
        end else begin
            case (state_ff)
                iovfh_pkg::ST_OFF: begin
                    // off then on also releases a latched fault
                    nxt_state = iovfh_pkg::ST_RUN;
                end
                iovfh_pkg::ST_RUN: begin
                    if (ov_hit) begin
                        case (resp_code)
                            iovfh_pkg::RESP_IGNORE: ;
                            iovfh_pkg::RESP_DELAYED: begin
                                nxt_state = iovfh_pkg::ST_DELAY;
                                tmr_start = 1'b1;
                            end
                            iovfh_pkg::RESP_SHUTDOWN: begin
                                nxt_attempts = 3'h0;
                                if (retry_code == iovfh_pkg::RETRY_NONE) begin
                                    nxt_state = iovfh_pkg::ST_LATCH;
                                end else begin
                                    nxt_state = iovfh_pkg::ST_RETRY;
                                    tmr_start = 1'b1;
                                end
                            end
                            default: nxt_state = iovfh_pkg::ST_LATCH;
                        endcase
                    end
                end
                iovfh_pkg::ST_DELAY: begin
                    if (tmr_done) begin
                        nxt_attempts = 3'h0;
                        if (!ov_hit) begin
                            nxt_state = iovfh_pkg::ST_RUN;
                        end else if (retry_code == iovfh_pkg::RETRY_NONE) begin
                            nxt_state = iovfh_pkg::ST_LATCH;
                        end else begin
                            nxt_state = iovfh_pkg::ST_RETRY;
                            tmr_start = 1'b1;
                        end
                    end
                end
                iovfh_pkg::ST_RETRY: begin
                    // an attempt fails when the fault is still present
                    if (tmr_done) begin
                        if (!ov_hit) begin
                            nxt_state = iovfh_pkg::ST_RUN;
                        end else if (retry_code == iovfh_pkg::RETRY_FOREVER) begin
                            tmr_start = 1'b1;
                        end else begin
                            nxt_attempts = attempts_ff + 3'h1;
                            if (nxt_attempts < retry_code) begin
                                tmr_start = 1'b1;
                            end else begin
                                nxt_state = iovfh_pkg::ST_LATCH;
                            end
                        end
                    end
                end
                iovfh_pkg::ST_LATCH: begin
                    if (clear_faults || host_clr_fault) begin
                        nxt_state = iovfh_pkg::ST_RUN;
                    end
                end
                default: nxt_state = iovfh_pkg::ST_OFF;
            endcase
        end
    end

    assign tmr_stop = (nxt_state != iovfh_pkg::ST_DELAY)
        && (nxt_state != iovfh_pkg::ST_RETRY);

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_ff <= iovfh_pkg::ST_OFF;
            attempts_ff <= 3'h0;
        end else if (ce) begin
            state_ff <= nxt_state;
            attempts_ff <= nxt_attempts;
        end
    end

    // output stays on while running and while the delayed action waits
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            out_en_ff <= 1'b0;
        end else if (ce) begin
            out_en_ff <= (nxt_state == iovfh_pkg::ST_RUN)
                || (nxt_state == iovfh_pkg::ST_DELAY);
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ratio_ff <= 1'b0;
        end else if (ce) begin
            ratio_ff <= maker_extra_option_settings && uvw_hit;
        end
    end

    assign rsp = rsp_ff;
    assign output_enable = out_en_ff;
    assign ratio_regulation_mode = ratio_ff;
    assign input_status = status_ff;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_FAULT_LIM_WRITE: assert property (
        ce && req.wr && req.code == iovfh_pkg::CMD_OV_FAULT_LIM
        |=> ov_fault_lim_ff == $past(req.wdata))
        else $error("fault limit write not stored");
    AST_WARN_LIM_WRITE: assert property (
        ce && req.wr && req.code == iovfh_pkg::CMD_OV_WARN_LIM
        |=> ov_warn_lim_ff == $past(req.wdata))
        else $error("warning limit write not stored");
    AST_IGNORE_KEEPS_ON: assert property (
        ce && state_ff == iovfh_pkg::ST_RUN && resp_code == 2'h0
        && on_command && !other_fault_off |=> output_enable)
        else $error("output dropped with ignore response");
    AST_SHUTDOWN_NOW: assert property (
        ce && state_ff == iovfh_pkg::ST_RUN && ov_hit && resp_code[1]
        |=> !output_enable)
        else $error("output not disabled on fault");
    AST_DELAY_KEEPS_ON: assert property (
        ce && state_ff == iovfh_pkg::ST_RUN && ov_hit && resp_code == 2'h1
        && on_command && !other_fault_off
        |=> output_enable && state_ff == iovfh_pkg::ST_DELAY)
        else $error("delayed response did not keep running");
    AST_LATCH_HOLDS: assert property (
        ce && state_ff == iovfh_pkg::ST_LATCH && on_command
        && !other_fault_off && !clear_faults && !host_clr_fault
        |=> state_ff == iovfh_pkg::ST_LATCH && !output_enable)
        else $error("latched fault released without clear");
    AST_NO_RETRY: assert property (
        ce && state_ff == iovfh_pkg::ST_RUN && ov_hit && resp_code == 2'h2
        && retry_code == 3'h0 && on_command && !other_fault_off
        |=> state_ff == iovfh_pkg::ST_LATCH)
        else $error("retry 000 did not latch off");
    AST_RETRY_COUNT: assert property (
        state_ff == iovfh_pkg::ST_RETRY |-> attempts_ff < retry_code
        || retry_code == 3'h7)
        else $error("retry count exceeded");
    AST_OFF_CMD: assert property (
        ce && !on_command |=> state_ff == iovfh_pkg::ST_OFF && !output_enable)
        else $error("off command ignored");
    // flag stands until a clear is taken with no fresh detection
    AST_STATUS_STICKY: assert property (
        ce && ov_hit |=> status_ff[0] ##0 ((ce && !ov_hit
        && (clear_faults || host_clr_fault)) or ##1 status_ff[0]))
        else $error("fault flag not set or not held");
    AST_RATIO_GATED: assert property (
        ratio_regulation_mode |-> $past(maker_extra_option_settings)
        || !$past(ce))
        else $error("ratio mode active while disabled");

    CV_DELAY_RECOVER: cover property (state_ff == iovfh_pkg::ST_DELAY
        ##1 state_ff == iovfh_pkg::ST_RUN);
    CV_RETRY_LATCH: cover property (state_ff == iovfh_pkg::ST_RETRY
        ##1 state_ff == iovfh_pkg::ST_LATCH);
    CV_LATCH_CLEAR: cover property (state_ff == iovfh_pkg::ST_LATCH
        ##1 state_ff == iovfh_pkg::ST_RUN);
endmodule

// *** test/iovfh_host_model.sv ***
// management host model issuing one-word command accesses
`timescale 1ns/1ps
module iovfh_host_model (
    // clock
    input wire logic mclk,
    // command port
    output iovfh_pkg::iovfh_req_s req,
    input wire iovfh_pkg::iovfh_rsp_s rsp
);
    initial req = '0;

    // strobe is a one-cycle pulse; answer is awaited for a few cycles only
    task automatic access(input logic wr, input logic [7:0] code,
        input logic [15:0] wdata, output logic [15:0] rdata,
        output logic err);
        int n;
        @(negedge mclk);
        req.wr = wr;
        req.rd = !wr;
        req.code = code;
        req.wdata = wdata;
        @(negedge mclk);
        // released fields show no stale value
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.code = ~code;
        req.wdata = ~wdata;
        n = 0;
        while (rsp.valid !== 1'b1 && n < 4) begin
            @(negedge mclk);
            n++;
        end
        rdata = (n < 4) ? rsp.rdata : 16'hXXXX;
        err = (n < 4) ? rsp.err : 1'bx;
    endtask
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the input over-voltage fault handler
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [7:0] code;
        logic [15:0] wdata;
        logic [15:0] exp;
        logic err;
    } iovfh_row_s;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [15:0] vin_meas = 16'h0600;
    logic [15:0] delay_unit_ticks = 16'h0002;
    logic maker_extra_option_settings = 1'b0;
    logic on_command = 1'b1;
    logic clear_faults = 1'b0;
    logic other_fault_off = 1'b0;
    iovfh_pkg::iovfh_req_s req;
    iovfh_pkg::iovfh_rsp_s rsp;
    logic output_enable;
    logic ratio_regulation_mode;
    logic [3:0] input_status;
    int bad_count = 0;
    int cmp_count = 0;
    int n;
    logic [15:0] rd;
    logic er;
    iovfh_row_s rows [6] = '{
        '{8'h55, 16'h1000, 16'h1000, 1'b0},
        '{8'h56, 16'h00AB, 16'h00AB, 1'b0},
        '{8'h57, 16'h0800, 16'h0800, 1'b0},
        '{8'h58, 16'h0400, 16'h0400, 1'b0},
        '{8'h20, 16'h1234, 16'h0000, 1'b1},
        '{8'hF0, 16'h5A5A, 16'h0000, 1'b1}};

    always #2.5 mclk = ~mclk;

    iovfh_top #(.TICK_W(16)) u_iovfh_top (
        .mclk(mclk), .resetn(resetn), .ce(ce), .req(req), .rsp(rsp),
        .vin_meas(vin_meas), .delay_unit_ticks(delay_unit_ticks),
        .maker_extra_option_settings(maker_extra_option_settings),
        .on_command(on_command), .clear_faults(clear_faults),
        .other_fault_off(other_fault_off), .output_enable(output_enable),
        .ratio_regulation_mode(ratio_regulation_mode),
        .input_status(input_status));

    iovfh_host_model u_iovfh_host_model (
        .mclk(mclk), .req(req), .rsp(rsp));

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        u_iovfh_host_model.access(1'b1, c, d, rd, er);
    endtask

    task automatic rdc(input logic [7:0] c);
        u_iovfh_host_model.access(1'b0, c, 16'h0000, rd, er);
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    // bounded wait, caller compares the level afterwards
    task automatic wait_oe(input logic v, input int max);
        n = 0;
        while (output_enable !== v && n < max) begin
            @(negedge mclk);
            n++;
        end
    endtask

    task automatic recover();
        vin_meas = 16'h0600;
        clear_faults = 1'b1;
        @(negedge mclk);
        clear_faults = 1'b0;
        wait_oe(1'b1, 300);
        chk_bit(output_enable, 1'b1);
        wr(8'hF1, 16'h000F);
    endtask

    task automatic final_report();
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // whole run is well under a thousand cycles
    initial begin
        #20000;
        bad_count++;
        final_report();
    end

    initial begin
        cyc(10);
        resetn = 1'b1;
        cyc(2);
        chk_bit(output_enable, 1'b1);
        rdc(8'h55);
        chk_word(rd, 16'hFFFF);
        rdc(8'h57);
        chk_word(rd, 16'hFFFF);
        rdc(8'h58);
        chk_word(rd, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i].code, rows[i].wdata);
            chk_bit(er, rows[i].err);
            rdc(rows[i].code);
            chk_word(rd, rows[i].exp);
            chk_bit(er, rows[i].err);
        end
        // ignore response: status only
        wr(8'h56, 16'h0000);
        vin_meas = 16'h0900;
        cyc(4);
        chk_word({12'h000, input_status}, 16'h0002);
        vin_meas = 16'h1100;
        cyc(4);
        chk_bit(input_status[0], 1'b1);
        chk_bit(output_enable, 1'b1);
        vin_meas = 16'h0600;
        cyc(4);
        chk_word({12'h000, input_status}, 16'h0003);
        wr(8'hF1, 16'h0007);
        rdc(8'hF1);
        chk_word(rd, 16'h0000);
        // shut down, two retries of 2 units of 2 cycles
        wr(8'h56, 16'h0091);
        vin_meas = 16'h1100;
        wait_oe(1'b0, 4);
        chk_bit(output_enable, 1'b0);
        n = 0;
        while (input_status[3] !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
            chk_bit(output_enable, 1'b0);
        end
        chk_bit(n >= 7 && n <= 13, 1'b1);
        vin_meas = 16'h0600;
        cyc(20);
        chk_bit(output_enable, 1'b0);
        recover();
        // no retry
        wr(8'h56, 16'h0080);
        vin_meas = 16'h1100;
        cyc(6);
        chk_bit(input_status[3], 1'b1);
        vin_meas = 16'h0600;
        cyc(20);
        chk_bit(output_enable, 1'b0);
        recover();
        // latch off, left by an off-then-on command
        wr(8'h56, 16'h00C9);
        vin_meas = 16'h1100;
        wait_oe(1'b0, 4);
        vin_meas = 16'h0600;
        cyc(30);
        chk_bit(output_enable, 1'b0);
        on_command = 1'b0;
        cyc(3);
        on_command = 1'b1;
        wait_oe(1'b1, 10);
        chk_bit(output_enable, 1'b1);
        wr(8'hF1, 16'h000F);
        // endless retry never latches
        wr(8'h56, 16'h00B9);
        vin_meas = 16'h1100;
        cyc(80);
        chk_bit(input_status[3], 1'b0);
        chk_bit(output_enable, 1'b0);
        // another fault takes over: stays off even once input is fine
        other_fault_off = 1'b1;
        cyc(2);
        vin_meas = 16'h0600;
        cyc(20);
        chk_bit(output_enable, 1'b0);
        chk_bit(input_status[3], 1'b0);
        other_fault_off = 1'b0;
        wait_oe(1'b1, 20);
        chk_bit(output_enable, 1'b1);
        wr(8'hF1, 16'h000F);
        // run on for 4 units of 4 cycles before acting
        delay_unit_ticks = 16'h0004;
        wr(8'h56, 16'h0042);
        vin_meas = 16'h1100;
        cyc(12);
        chk_bit(output_enable, 1'b1);
        wait_oe(1'b0, 15);
        chk_bit(output_enable, 1'b0);
        recover();
        // ratio regulation threshold
        vin_meas = 16'h0300;
        cyc(4);
        chk_bit(ratio_regulation_mode, 1'b0);
        maker_extra_option_settings = 1'b1;
        cyc(4);
        chk_bit(ratio_regulation_mode, 1'b1);
        vin_meas = 16'h0500;
        cyc(4);
        chk_bit(ratio_regulation_mode, 1'b0);
        // clock enable low: a fault level must leave no trace
        ce = 1'b0;
        vin_meas = 16'h1100;
        cyc(6);
        chk_bit(input_status[0], 1'b0);
        chk_bit(output_enable, 1'b1);
        vin_meas = 16'h0600;
        cyc(1);
        ce = 1'b1;
        cyc(4);
        chk_bit(input_status[0], 1'b0);
        // second reset in mid-run restores the limit
        resetn = 1'b0;
        cyc(3);
        resetn = 1'b1;
        cyc(1);
        chk_bit(output_enable, 1'b1);
        chk_word({12'h000, input_status}, 16'h0000);
        rdc(8'h55);
        chk_word(rd, 16'hFFFF);
        final_report();
    end
endmodule
